/* verilog/sirqel_regs.svh */
`ifndef SIRQEL_REGS_SVH
`define SIRQEL_REGS_SVH

// ----------------------------------------
// Register indices, byte address is index*4
// ----------------------------------------
`define SIRQEL_IDX_MODE   8'h40
`define SIRQEL_IDX_EXC    8'hf0
`define SIRQEL_IDX_CLK    8'hf1
`define SIRQEL_IDX_LOG    8'hf2

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SIRQEL_B_EN       7
`define SIRQEL_B_MD       6
`define SIRQEL_F_FMT      5:2
`define SIRQEL_F_PW       1:0
`define SIRQEL_B_CHK_LK   5
`define SIRQEL_B_SMI_LK   4
`define SIRQEL_B_CHK_EN   1
`define SIRQEL_B_SMI_EN   0
`define SIRQEL_B_GATE     0
`define SIRQEL_F_FLAGS    3:0
`define SIRQEL_B_IDLE     3
`define SIRQEL_B_NPCHK    2
`define SIRQEL_B_ABORT    1
`define SIRQEL_B_UNCL     0

// ----------------------------------------
// Reset values and fixed codes
// ----------------------------------------
`define SIRQEL_RST_PW     2'h0
`define SIRQEL_RST_GATE   1'h1
`define SIRQEL_FMT_21     4'h4
`define SIRQEL_PW_4       2'h0
`define SIRQEL_PW_6       2'h1
`define SIRQEL_PW_8       2'h2

// ----------------------------------------
// Frame timing in clocks
// ----------------------------------------
`define SIRQEL_LEN_4      4'h4
`define SIRQEL_LEN_6      4'h6
`define SIRQEL_LEN_8      4'h8
`define SIRQEL_STOP_Q     4'h2
`define SIRQEL_STOP_C     4'h3
`define SIRQEL_SLOTS_LAST 5'h14
`define SIRQEL_SLOT_SMI   5'h03
`define SIRQEL_SLOT_CHK   5'h11
`define SIRQEL_PH_LAST    2'h2
`define SIRQEL_PH_SAMPLE  2'h2

`endif

/* verilog/sirqel_pkg.sv */
`include "sirqel_regs.svh"

package sirqel_pkg;

	typedef enum logic [2:0] {
		SIRQEL_IDLE,
		SIRQEL_START,
		SIRQEL_RECOV,
		SIRQEL_TURN,
		SIRQEL_SLOT,
		SIRQEL_STOP,
		SIRQEL_SREC
	} sirqel_state_t;

	typedef struct packed {
		sirqel_state_t state;
		logic [3:0]    cnt;
		logic [4:0]    slot;
		logic [1:0]    phase;
		logic          en;
		logic          md;
		logic [1:0]    pw;
		logic          chk_en;
		logic          chk_lk;
		logic          smi_en;
		logic          smi_lk;
		logic          gate;
		logic          ack;
		logic [7:0]    rdata;
		logic          smi_n;
		logic          chk_n;
		logic          chk_evt;
		logic          drv;
		logic          oe;
	} sirqel_top_t;

	typedef struct packed {
		logic [3:0]  flags;
		logic [31:0] addr;
		logic        rd;
		logic        io;
	} sirqel_log_t;

	typedef struct packed {
		logic meta;
		logic sync;
	} sirqel_sync_t;

endpackage

/* verilog/sirqel_sync.sv */
`timescale 1ns/1ps

module sirqel_sync
	import sirqel_pkg::*;
(
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic rst_b,
	// Pin side
	input  wire logic pin_in,
	// Synchronised level
	output logic      pin_sync
);

	sirqel_sync_t s_q;
	sirqel_sync_t s_d;

	always_comb
	begin
		s_d.meta = pin_in;
		s_d.sync = s_q.meta;
	end

	// Idle pin level is high
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			s_q <= '{meta: 1'b1, sync: 1'b1};
		else
			s_q <= s_d;
	end

	assign pin_sync = s_q.sync;

endmodule

/* verilog/sirqel_errlog.sv */
`timescale 1ns/1ps
`include "sirqel_regs.svh"

module sirqel_errlog
	import sirqel_pkg::*;
(
	// Clock and eSPI reset
	input  wire logic        clk_sys,
	input  wire logic        espi_rst_b,
	// Events from the bridge
	input  wire logic        chk_evt,
	input  wire logic        lpc_busy,
	input  wire logic        lpc_nonposted,
	input  wire logic        lpc_abort,
	input  wire logic        lpc_unclaimed,
	input  wire logic        lpc_rd,
	input  wire logic        lpc_io,
	input  wire logic [31:0] lpc_addr,
	// Software clear mask
	input  wire logic [3:0]  clr,
	// Log contents
	output logic [3:0]       flags,
	output logic [31:0]      err_addr,
	output logic             err_rd,
	output logic             err_io
);

	sirqel_log_t s_q;
	sirqel_log_t s_d;
	logic [3:0]  set;

	always_comb
	begin
		set = 4'h0;
		set[`SIRQEL_B_IDLE]  = chk_evt & ~lpc_busy;
		set[`SIRQEL_B_NPCHK] = chk_evt & lpc_busy & lpc_nonposted;
		set[`SIRQEL_B_ABORT] = lpc_abort & lpc_nonposted;
		set[`SIRQEL_B_UNCL]  = lpc_unclaimed & lpc_nonposted;
		s_d = s_q;
		s_d.flags = (s_q.flags & ~clr) | set;
		if (|set[`SIRQEL_B_NPCHK:`SIRQEL_B_UNCL])
		begin
			s_d.addr = lpc_addr;
			s_d.rd   = lpc_rd;
			s_d.io   = lpc_io;
		end
	end

	always_ff @(posedge clk_sys or negedge espi_rst_b)
	begin
		if (!espi_rst_b)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign flags    = s_q.flags;
	assign err_addr = s_q.addr;
	assign err_rd   = s_q.rd;
	assign err_io   = s_q.io;

endmodule

/* verilog/sirqel_top.sv */
`timescale 1ns/1ps
`include "sirqel_regs.svh"

// What this block does
// - Serial IRQ frames run only while the enable bit is set, which is clear after reset.
// - Mode bit one runs continuous frames, zero runs quiet frames started by a peripheral.
// - Frames always hold 21 slots and a read-only field at bits 5 to 2 reads the fixed code.
// - Start pulse lasts 4, 6 or 8 clocks for width codes 00, 01, 10 in continuous mode, one clock less in quiet mode; 11 is reserved; 4 is the reset.
// - With the check enable set, slot 17 of each frame is sampled and passed on to eSPI.
// - With the management enable set, slot 3 is sampled and passed on as the SMI virtual wire.
// - Clock gate bit one, its reset value, keeps the circuits clocked; zero allows stopping when idle.
// - A check event while no LPC transfer runs sets the idle flag at bit 3 until cleared.
// - A check event during a non-posted transfer sets the flag at bit 2.
// - A non-posted transfer ending in an abort sync sets the flag at bit 1.
// - A non-posted transfer unclaimed or with an invalid sync sets the flag at bit 0.
// - Error flags stay set until software writes one to them; zero leaves them alone.
// - On an LPC error the direction, space and presented address are recorded.
module sirqel_top
	import sirqel_pkg::*;
(
	// Clock and resets
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	input  wire logic        espi_rst_b,
	// Avalon-MM slave
	input  wire logic [9:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	// Serial IRQ open-drain pin
	input  wire logic        ser_irq_in,
	output logic             ser_irq_out,
	output logic             ser_irq_oe,
	// LPC transfer status
	input  wire logic        lpc_busy,
	input  wire logic        lpc_nonposted,
	input  wire logic        lpc_abort,
	input  wire logic        lpc_unclaimed,
	input  wire logic        lpc_rd,
	input  wire logic        lpc_io,
	input  wire logic [31:0] lpc_addr,
	// eSPI virtual wires
	output logic             espi_smi_n,
	output logic             espi_chk_n,
	output logic             espi_chk_evt,
	// Clock request and error capture
	output logic             ser_clk_req,
	output logic [31:0]      err_addr,
	output logic             err_rd,
	output logic             err_io
);

	sirqel_top_t s_q;
	sirqel_top_t s_d;
	logic        ser_s;
	logic        req;
	logic        wr_go;
	logic        rd_go;
	logic        hit_mode;
	logic        hit_exc;
	logic        hit_clk;
	logic        hit_log;
	logic [3:0]  log_clr;
	logic [3:0]  log_flags;
	logic [3:0]  start_len;
	logic [7:0]  wd;

	// ----------------------------------------
	// Pin synchroniser
	// ----------------------------------------
	sirqel_sync u_sync (
		.clk_sys  (clk_sys),
		.rst_b    (rst_b),
		.pin_in   (ser_irq_in),
		.pin_sync (ser_s)
	);

	// ----------------------------------------
	// Error log
	// ----------------------------------------
	sirqel_errlog u_log (
		.clk_sys       (clk_sys),
		.espi_rst_b    (espi_rst_b),
		.chk_evt       (s_q.chk_evt),
		.lpc_busy      (lpc_busy),
		.lpc_nonposted (lpc_nonposted),
		.lpc_abort     (lpc_abort),
		.lpc_unclaimed (lpc_unclaimed),
		.lpc_rd        (lpc_rd),
		.lpc_io        (lpc_io),
		.lpc_addr      (lpc_addr),
		.clr           (log_clr),
		.flags         (log_flags),
		.err_addr      (err_addr),
		.err_rd        (err_rd),
		.err_io        (err_io)
	);

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	assign req      = avs_read | avs_write;
	assign wr_go    = avs_write & s_q.ack & avs_byteenable[0];
	assign rd_go    = avs_read & ~s_q.ack;
	assign wd       = avs_writedata[7:0];
	assign hit_mode = avs_address == {`SIRQEL_IDX_MODE, 2'b00};
	assign hit_exc  = avs_address == {`SIRQEL_IDX_EXC, 2'b00};
	assign hit_clk  = avs_address == {`SIRQEL_IDX_CLK, 2'b00};
	assign hit_log  = avs_address == {`SIRQEL_IDX_LOG, 2'b00};
	assign log_clr  = (wr_go && hit_log) ? wd[`SIRQEL_F_FLAGS] : 4'h0;

	always_comb
	begin
		if (s_q.pw == `SIRQEL_PW_6)
			start_len = `SIRQEL_LEN_6;
		else if (s_q.pw == `SIRQEL_PW_8)
			start_len = `SIRQEL_LEN_8;
		else
			start_len = `SIRQEL_LEN_4;
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		s_d         = s_q;
		s_d.ack     = req & ~s_q.ack;
		s_d.chk_evt = 1'b0;

		// Register writes
		if (wr_go && hit_mode)
		begin
			s_d.en = wd[`SIRQEL_B_EN];
			s_d.md = wd[`SIRQEL_B_MD];
			s_d.pw = wd[`SIRQEL_F_PW];
		end
		else if (wr_go && hit_exc)
		begin
			if (!s_q.chk_lk)
			begin
				s_d.chk_en = wd[`SIRQEL_B_CHK_EN];
				s_d.chk_lk = wd[`SIRQEL_B_CHK_LK];
			end
			if (!s_q.smi_lk)
			begin
				s_d.smi_en = wd[`SIRQEL_B_SMI_EN];
				s_d.smi_lk = wd[`SIRQEL_B_SMI_LK];
			end
		end
		else if (wr_go && hit_clk)
		begin
			s_d.gate = wd[`SIRQEL_B_GATE];
		end

		// Register reads
		if (rd_go)
		begin
			s_d.rdata = 8'h00;
			if (hit_mode)
			begin
				s_d.rdata[`SIRQEL_B_EN] = s_q.en;
				s_d.rdata[`SIRQEL_B_MD] = s_q.md;
				s_d.rdata[`SIRQEL_F_FMT] = `SIRQEL_FMT_21;
				s_d.rdata[`SIRQEL_F_PW]  = s_q.pw;
			end
			else if (hit_exc)
			begin
				s_d.rdata[`SIRQEL_B_CHK_LK] = s_q.chk_lk;
				s_d.rdata[`SIRQEL_B_SMI_LK] = s_q.smi_lk;
				s_d.rdata[`SIRQEL_B_CHK_EN] = s_q.chk_en;
				s_d.rdata[`SIRQEL_B_SMI_EN] = s_q.smi_en;
			end
			else if (hit_clk)
			begin
				s_d.rdata[`SIRQEL_B_GATE] = s_q.gate;
			end
			else if (hit_log)
			begin
				s_d.rdata[`SIRQEL_F_FLAGS] = log_flags;
			end
		end

		// Serial IRQ frame sequencer
		case (s_q.state)
			SIRQEL_IDLE:
			begin
				s_d.oe = 1'b0;
				// Own stop pulse still in the synchroniser
				if (s_q.cnt != 4'h0)
					s_d.cnt = s_q.cnt - 4'h1;
				if (s_q.en)
				begin
					if (s_q.md)
					begin
						s_d.state = SIRQEL_START;
						s_d.cnt   = start_len;
						s_d.oe    = 1'b1;
						s_d.drv   = 1'b0;
					end
					else if (!ser_s && s_q.cnt == 4'h0)
					begin
						s_d.state = SIRQEL_START;
						s_d.cnt   = start_len - 4'h1;
						s_d.oe    = 1'b1;
						s_d.drv   = 1'b0;
					end
				end
			end
			SIRQEL_START:
			begin
				if (s_q.cnt <= 4'h1)
				begin
					s_d.state = SIRQEL_RECOV;
					s_d.drv   = 1'b1;
				end
				else
					s_d.cnt = s_q.cnt - 4'h1;
			end
			SIRQEL_RECOV:
			begin
				s_d.oe    = 1'b0;
				s_d.state = SIRQEL_TURN;
			end
			SIRQEL_TURN:
			begin
				s_d.state = SIRQEL_SLOT;
				s_d.slot  = 5'h00;
				s_d.phase = 2'h0;
			end
			SIRQEL_SLOT:
			begin
				// Two clocks of sync lag land on phase 2
				if (s_q.phase == `SIRQEL_PH_SAMPLE)
				begin
					if (s_q.smi_en && s_q.slot == `SIRQEL_SLOT_SMI)
						s_d.smi_n = ser_s;
					if (s_q.chk_en && s_q.slot == `SIRQEL_SLOT_CHK)
					begin
						s_d.chk_n   = ser_s;
						s_d.chk_evt = ~ser_s;
					end
				end
				if (s_q.phase == `SIRQEL_PH_LAST)
				begin
					s_d.phase = 2'h0;
					s_d.slot  = s_q.slot + 5'h01;
					if (s_q.slot == `SIRQEL_SLOTS_LAST)
					begin
						s_d.state = SIRQEL_STOP;
						s_d.cnt   = s_q.md ? `SIRQEL_STOP_C : `SIRQEL_STOP_Q;
						s_d.oe    = 1'b1;
						s_d.drv   = 1'b0;
					end
				end
				else
					s_d.phase = s_q.phase + 2'h1;
			end
			SIRQEL_STOP:
			begin
				if (s_q.cnt <= 4'h1)
				begin
					s_d.state = SIRQEL_SREC;
					s_d.drv   = 1'b1;
				end
				else
					s_d.cnt = s_q.cnt - 4'h1;
			end
			SIRQEL_SREC:
			begin
				s_d.oe    = 1'b0;
				s_d.state = SIRQEL_IDLE;
			end
			default:
			begin
				s_d.state = SIRQEL_IDLE;
				s_d.oe    = 1'b0;
			end
		endcase

		if (!s_q.en)
		begin
			s_d.state = SIRQEL_IDLE;
			s_d.oe    = 1'b0;
			s_d.drv   = 1'b1;
		end
		if (!s_q.smi_en)
			s_d.smi_n = 1'b1;
		if (!s_q.chk_en)
			s_d.chk_n = 1'b1;
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	// configuration on platform reset
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			s_q       <= '0;
			s_q.state <= SIRQEL_IDLE;
			s_q.pw    <= `SIRQEL_RST_PW;
			s_q.gate  <= `SIRQEL_RST_GATE;
			s_q.smi_n <= 1'b1;
			s_q.chk_n <= 1'b1;
			s_q.drv   <= 1'b1;
		end
		else
			s_q <= s_d;
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign avs_waitrequest = req & ~s_q.ack;
	assign avs_readdata    = {24'h000000, s_q.rdata};
	assign ser_irq_out     = s_q.drv;
	assign ser_irq_oe      = s_q.oe;
	assign espi_smi_n      = s_q.smi_n;
	assign espi_chk_n      = s_q.chk_n;
	assign espi_chk_evt    = s_q.chk_evt;
	// clock request while gated on or busy
	assign ser_clk_req     = s_q.gate | (s_q.state != SIRQEL_IDLE);

endmodule

/* testbench/sirqel_periph.sv */
`timescale 1ns/1ps

module sirqel_periph
(
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic rst_b,
	// Wired pin and requests
	input  wire logic pin,
	input  wire logic want_smi,
	input  wire logic want_chk,
	input  wire logic qstart,
	// Pull-down
	output logic      drive_low
);
	// ----
	// Frame follower
	// ----
	logic [1:0] low_q;
	logic [6:0] cnt_q;

	always_ff @(posedge clk_sys or negedge rst_b)
		if (!rst_b)
		begin
			low_q <= 2'h0;
			cnt_q <= 7'h64;
		end
		else
		begin
			low_q <= pin ? 2'h0 : (low_q == 2'h3 ? 2'h3 : low_q + 2'h1);
			// Long low run outside the stop window starts slots
			if (pin && low_q == 2'h3 && (cnt_q < 7'h3c || cnt_q > 7'h44))
				cnt_q <= 7'h00;
			else if (cnt_q != 7'h64)
				cnt_q <= cnt_q + 7'h01;
		end

	// Pull in phase 0 of the slot, or at any time while qstart is set
	assign drive_low = qstart || (want_smi && cnt_q == 7'h0a) || (want_chk && cnt_q == 7'h34);
endmodule

/* testbench/sirqel_assertions.sv */
`timescale 1ns/1ps

module sirqel_assertions
(
	// Clock and resets
	input wire logic        clk_sys,
	input wire logic        rst_b,
	input wire logic        espi_rst_b,
	// Register bus
	input wire logic [9:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0]  avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	// Pin, wires and log
	input wire logic        ser_irq_oe,
	input wire logic        espi_smi_n,
	input wire logic        espi_chk_n,
	input wire logic        espi_chk_evt,
	input wire logic        ser_clk_req,
	input wire logic        lpc_nonposted,
	input wire logic        lpc_abort,
	input wire logic        lpc_unclaimed,
	input wire logic        lpc_rd,
	input wire logic        lpc_io,
	input wire logic [31:0] lpc_addr,
	input wire logic [31:0] err_addr,
	input wire logic        err_rd,
	input wire logic        err_io
);
	// ----
	// Shadow of written configuration
	// ----
	logic gate_q, en_q, md_q, ce_q, cl_q, se_q, sl_q;
	wire  wr = avs_write && !avs_waitrequest && avs_byteenable[0];

	always_ff @(posedge clk_sys or negedge rst_b)
		if (!rst_b)
			{gate_q, en_q, md_q, ce_q, cl_q, se_q, sl_q} <= 7'h40;
		else if (wr)
		begin
			if (avs_address == 10'h100)
				{en_q, md_q} <= avs_writedata[7:6];
			if (avs_address == 10'h3c4)
				gate_q <= avs_writedata[0];
			if (avs_address == 10'h3c0 && !cl_q)
				{cl_q, ce_q} <= {avs_writedata[5], avs_writedata[1]};
			if (avs_address == 10'h3c0 && !sl_q)
				{sl_q, se_q} <= {avs_writedata[4], avs_writedata[0]};
		end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	property p_off; !en_q && !$past(en_q) |-> !ser_irq_oe; endproperty
	a_off: assert property (p_off) else $error("frame while disabled");
	property p_cont; en_q && md_q && !ser_irq_oe |-> ##[1:100] (ser_irq_oe || !en_q || !md_q); endproperty
	a_cont: assert property (p_cont) else $error("no continuous frame");
	property p_fmt; avs_read && !avs_waitrequest && avs_address == 10'h100 |-> avs_readdata[5:2] == 4'h4; endproperty
	a_fmt: assert property (p_fmt) else $error("format field wrong");
	property p_chk; !ce_q && !$past(ce_q) |-> espi_chk_n && !espi_chk_evt; endproperty
	a_chk: assert property (p_chk) else $error("check slot passed while off");
	property p_evt; espi_chk_evt |=> !espi_chk_evt; endproperty
	a_evt: assert property (p_evt) else $error("check event too long");
	property p_smi; !se_q && !$past(se_q) |-> espi_smi_n; endproperty
	a_smi: assert property (p_smi) else $error("mgmt slot passed while off");
	property p_gate; gate_q || ser_irq_oe |-> ser_clk_req; endproperty
	a_gate: assert property (p_gate) else $error("clock request dropped");
	property p_cap;
		disable iff (!espi_rst_b) (lpc_abort || lpc_unclaimed) && lpc_nonposted
		|=> err_addr == $past(lpc_addr) && err_rd == $past(lpc_rd) && err_io == $past(lpc_io);
	endproperty
	a_cap: assert property (p_cap) else $error("error capture wrong");
endmodule

/* testbench/testbench.sv */
`timescale 1ns/1ps

module testbench;
	// ----
	// Wiring
	// ----
	logic        clk_sys = 1'b0;
	logic        rst_b, espi_rst_b, avs_read, avs_write, want_smi, want_chk, qstart;
	logic        lpc_busy, lpc_nonposted, lpc_abort, lpc_unclaimed, lpc_rd, lpc_io;
	logic [9:0]  avs_address;
	logic [31:0] avs_writedata, lpc_addr, avs_readdata, err_addr;
	logic [3:0]  avs_byteenable;
	logic        avs_waitrequest, ser_irq_out, ser_irq_oe, espi_smi_n, espi_chk_n;
	logic        espi_chk_evt, ser_clk_req, err_rd, err_io, p_low;
	int          failures = 0;
	int          tests_run = 0;
	int          evts = 0;
	// Open drain with pull-up
	wire         ser_irq_in = !((ser_irq_oe === 1'b1 && ser_irq_out === 1'b0) || p_low === 1'b1);

	sirqel_top DUT (.*);
	sirqel_periph u_per (.clk_sys, .rst_b, .pin(ser_irq_in), .want_smi, .want_chk, .qstart, .drive_low(p_low));

	always #50 clk_sys = ~clk_sys;
	always @(posedge clk_sys)
		if (espi_chk_evt === 1'b1)
			evts++;

	// ----
	// Tasks
	// ----
	task stop_test;
		$display("failures=%0d tests_run=%0d", failures, tests_run);
		if (failures == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task cmp(input bit bad);
		tests_run++;
		if (bad)
		begin
			failures++;
			$display("MISMATCH %0t value differs", $time);
		end
	endtask

	task bus(input logic w, input logic [9:0] a, input logic [7:0] d, output logic [7:0] r);
		int i;
		@(posedge clk_sys);
		avs_address <= a;
		avs_writedata <= {24'h0, d};
		avs_write <= w;
		avs_read <= !w;
		i = 0;
		do
		begin
			@(posedge clk_sys);
			i++;
		end
		while (avs_waitrequest !== 1'b0 && i < 50);
		cmp(i >= 50);
		if (i >= 50)
			stop_test;
		r = avs_readdata[7:0];
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask

	task wr(input logic [9:0] a, input logic [7:0] d);
		logic [7:0] r;
		bus(1'b1, a, d, r);
	endtask

	task rd(input logic [9:0] a, input logic [7:0] e);
		logic [7:0] r;
		bus(1'b0, a, 8'h00, r);
		cmp(r !== e);
	endtask

	task wt(input logic v);
		int i;
		for (i = 0; i < 400 && ser_irq_oe !== v; i++)
			@(posedge clk_sys);
		cmp(i >= 400);
	endtask

	task frame;
		wt(1'b1);
		wt(1'b0);
		wt(1'b1);
		wt(1'b0);
		repeat (4) @(posedge clk_sys);
	endtask

	task restart;
		wr(10'h100, 8'h00);
		wr(10'h100, 8'hc0);
	endtask

	task meas(output int n);
		wt(1'b1);
		n = 0;
		while (ser_irq_oe === 1'b1 && ser_irq_out === 1'b0 && n < 20)
		begin
			@(posedge clk_sys);
			n++;
		end
	endtask

	task lpc(input logic ab, input logic un, input logic np, input logic r, input logic io, input logic [31:0] a);
		@(posedge clk_sys);
		{lpc_abort, lpc_unclaimed, lpc_nonposted, lpc_busy, lpc_rd, lpc_io} <= {ab, un, np, np, r, io};
		lpc_addr <= a;
		@(posedge clk_sys);
		{lpc_abort, lpc_unclaimed, lpc_nonposted, lpc_busy} <= 4'h0;
		@(posedge clk_sys);
	endtask

	initial
	begin
		#3000000;
		cmp(1'b1);
		stop_test;
	end

	// ----
	// Sequence
	// ----
	initial
	begin
		int n, e0;
		{rst_b, espi_rst_b, avs_read, avs_write, want_smi, want_chk, qstart} = '0;
		{lpc_busy, lpc_nonposted, lpc_abort, lpc_unclaimed, lpc_rd, lpc_io} = '0;
		{avs_address, avs_writedata, lpc_addr} = '0;
		avs_byteenable = 4'h1;
		repeat (16) @(posedge clk_sys);
		rst_b <= 1'b1;
		espi_rst_b <= 1'b1;
		rd(10'h100, 8'h10);
		rd(10'h3c0, 8'h00);
		rd(10'h3c4, 8'h01);
		rd(10'h3c8, 8'h00);
		rd(10'h004, 8'h00);
		cmp(ser_clk_req !== 1'b1);
		wr(10'h3c4, 8'h00);
		rd(10'h3c4, 8'h00);
		cmp(ser_clk_req !== 1'b0);
		wr(10'h3c4, 8'h01);
		for (int k = 0; k < 4; k++)
		begin
			wr(10'h100, 8'h00);
			wr(10'h100, {6'h3f, k[1:0]});
			meas(n);
			cmp(n != ((k == 3) ? 4 : 4 + 2 * k));
			rd(10'h100, {6'h34, k[1:0]});
		end
		want_smi <= 1'b1;
		want_chk <= 1'b1;
		restart;
		e0 = evts;
		frame;
		cmp(espi_smi_n !== 1'b1 || espi_chk_n !== 1'b1 || evts != e0);
		wr(10'h3c0, 8'h03);
		restart;
		e0 = evts;
		frame;
		cmp(espi_smi_n !== 1'b0 || espi_chk_n !== 1'b0 || evts != e0 + 1);
		rd(10'h3c8, 8'h08);
		wr(10'h3c8, 8'h08);
		want_smi <= 1'b0;
		lpc_busy <= 1'b1;
		lpc_nonposted <= 1'b1;
		frame;
		frame;
		cmp(espi_smi_n !== 1'b1);
		rd(10'h3c8, 8'h04);
		lpc_busy <= 1'b0;
		lpc_nonposted <= 1'b0;
		frame;
		want_chk <= 1'b0;
		frame;
		cmp(espi_chk_n !== 1'b1);
		rd(10'h3c8, 8'h0c);
		lpc(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 32'h0000_0a5c);
		rd(10'h3c8, 8'h0c);
		lpc(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 32'h0000_0a5c);
		cmp(err_addr !== 32'h0000_0a5c || err_rd !== 1'b1 || err_io !== 1'b1);
		rd(10'h3c8, 8'h0e);
		lpc(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 32'h8765_4320);
		cmp(err_addr !== 32'h8765_4320 || err_rd !== 1'b0 || err_io !== 1'b0);
		rd(10'h3c8, 8'h0f);
		wr(10'h3c8, 8'h00);
		rd(10'h3c8, 8'h0f);
		wr(10'h3c8, 8'h05);
		rd(10'h3c8, 8'h0a);
		avs_byteenable <= 4'h0;
		wr(10'h3c8, 8'h0a);
		avs_byteenable <= 4'h1;
		rd(10'h3c8, 8'h0a);
		wr(10'h3c0, 8'h22);
		wr(10'h3c0, 8'h00);
		rd(10'h3c0, 8'h22);
		wr(10'h3c0, 8'h11);
		wr(10'h3c0, 8'h00);
		rd(10'h3c0, 8'h33);
		rst_b <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rst_b <= 1'b1;
		rd(10'h100, 8'h10);
		rd(10'h3c0, 8'h00);
		rd(10'h3c8, 8'h0a);
		espi_rst_b <= 1'b0;
		@(posedge clk_sys);
		espi_rst_b <= 1'b1;
		rd(10'h3c8, 8'h00);
		cmp(err_addr !== 32'h0);
		wr(10'h100, 8'hc0);
		wr(10'h100, 8'h80);
		repeat (150) @(posedge clk_sys);
		n = 0;
		repeat (100)
		begin
			@(posedge clk_sys);
			n += (ser_irq_oe !== 1'b0);
		end
		cmp(n != 0);
		qstart <= 1'b1;
		@(posedge clk_sys);
		qstart <= 1'b0;
		meas(n);
		cmp(n != 3);
		stop_test;
	end
endmodule

bind sirqel_top sirqel_assertions u_chk (.*);
